// [design/scr_pkg.sv]
package scr_pkg;

    // bus and memory widths
    localparam int unsigned SCR_DW = 32;
    localparam int unsigned SCR_RAM_AW = 12;
    localparam int unsigned SCR_REG_W = 8;

    // register map: byte address of the system control register
    localparam logic [31:0] SCR_SYSCTL_OFFS = 32'h0000_0000;

    // field positions
    localparam int unsigned SCR_BIT_SRST = 1;
    localparam int unsigned SCR_BIT_ONCHIP_RAM_ENABLE = 0;

    // reset values
    localparam logic SCR_SRST_RST = 1'h0;
    localparam logic SCR_ONCHIP_RAM_ENABLE_RST = 1'h1;

    // fixed read values of the reserved fields
    localparam logic [1:0] SCR_RSVD_HI = 2'h3;
    localparam logic [3:0] SCR_RSVD_LO = 4'h0;

    // pattern returned by a read of the ram while it is disabled
    localparam logic [SCR_DW-1:0] SCR_RAM_UNDEF = 32'hDEAD_BEEF;

    // gate follows a write within this many ram accesses
    localparam int unsigned SCR_GATE_LAG = 2;

    // ahb-lite codes
    localparam logic [1:0] SCR_HTRANS_IDLE = 2'h0;
    localparam logic SCR_HRESP_OKAY = 1'h0;

    // data-phase state of the bus slave
    typedef enum logic [2:0] {
        SCR_PH_IDLE = 3'h1,
        SCR_PH_WRITE = 3'h2,
        SCR_PH_READ = 3'h4
    } scr_phase_t;

endpackage

// [design/scr_ram_if.sv]
`timescale 1ns/10ps
interface scr_ram_if;
    import scr_pkg::*;
    logic req;
    logic we;
    logic [SCR_RAM_AW-1:0] addr;
    logic [SCR_DW-1:0] wdata;
    logic [SCR_DW-1:0] rdata;
    logic rvalid;

    // cpu side: the gate receives requests and returns read data
    modport gate_up (
        input req,
        input we,
        input addr,
        input wdata,
        output rdata,
        output rvalid
    );

    // memory side: the gate issues requests and takes raw read data
    modport gate_dn (
        output req,
        output we,
        output addr,
        output wdata,
        input rdata
    );
endinterface

// [design/scr_bit_reg.sv]
`timescale 1ns/10ps
module scr_bit_reg #(
    parameter logic RST = 1'h0
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic i_d,
    output logic o_q
);
    logic q_reg;
    logic q_next;

    always_comb begin
        q_next = q_reg;
        if (i_we) begin
            q_next = i_d;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q_reg <= RST;
        end else if (i_ce) begin
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;
endmodule // scr_bit_reg

// [design/scr_ram_gate.sv]
`timescale 1ns/10ps
module scr_ram_gate
    import scr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_en,
    scr_ram_if.gate_up up,
    scr_ram_if.gate_dn dn
);
    logic rd_pend_reg;
    logic rd_pend_next;
    logic rd_ok_reg;
    logic rd_ok_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [SCR_DW-1:0] rdata_reg;
    logic [SCR_DW-1:0] rdata_next;

    // a disabled ram sees no request at all, so writes leave it untouched
    assign dn.req = up.req && i_en;
    assign dn.we = up.we && i_en;
    assign dn.addr = up.addr;
    assign dn.wdata = up.wdata;

    // the enable is sampled with the request, so a read in flight keeps
    // the answer it was issued under
    always_comb begin
        rd_pend_next = up.req && !up.we;
        rd_ok_next = i_en;
        rvalid_next = rd_pend_reg;
        rdata_next = rdata_reg;
        if (rd_pend_reg) begin
            rdata_next = rd_ok_reg ? dn.rdata : SCR_RAM_UNDEF;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rd_pend_reg <= 1'h0;
            rd_ok_reg <= 1'h0;
            rvalid_reg <= 1'h0;
            rdata_reg <= '0;
        end else if (i_ce) begin
            rd_pend_reg <= rd_pend_next;
            rd_ok_reg <= rd_ok_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
        end
    end

    assign up.rvalid = rvalid_reg;
    assign up.rdata = rdata_reg;

    a_write_blocked: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (up.req && !i_en) |-> (!dn.req && !dn.we))
        else $error("ram request passed while disabled");

    a_undef_read: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (up.req && !up.we && !i_en && i_ce) ##1 i_ce
        |=> (up.rvalid && up.rdata == SCR_RAM_UNDEF))
        else $error("disabled ram read did not return the fill pattern");
endmodule // scr_ram_gate

// [design/scr_sysctl.sv]
`timescale 1ns/10ps
module scr_sysctl
    import scr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_trace_debug_rst_n,
    output logic o_onchip_ram_enable,
    input wire logic i_cpu_ram_req,
    input wire logic i_cpu_ram_we,
    input wire logic [SCR_RAM_AW-1:0] i_cpu_ram_addr,
    input wire logic [SCR_DW-1:0] i_cpu_ram_wdata,
    output logic [SCR_DW-1:0] o_cpu_ram_rdata,
    output logic o_cpu_ram_rvalid,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [SCR_RAM_AW-1:0] o_mem_addr,
    output logic [SCR_DW-1:0] o_mem_wdata,
    input wire logic [SCR_DW-1:0] i_mem_rdata
);

////////////////////////////////////////////////////////////////////////////////

    scr_phase_t ph_reg;
    scr_phase_t ph_next;
    logic hit_reg;
    logic hit_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;

    logic take;
    logic addr_hit;
    logic wr_now;
    logic srst_q;
    logic onchip_ram_enable_q;
    logic srst_next;
    logic onchip_ram_enable_next;
    logic [SCR_REG_W-1:0] sys_view;

////////////////////////////////////////////////////////////////////////////////
// ahb-lite address phase

    // a frozen clock enable must also stall the bus, else a transfer
    // would complete against state that did not move
    assign o_hreadyout = i_ce;
    assign o_hresp = SCR_HRESP_OKAY;

    assign take = i_hsel && i_htrans[1] && i_hready && i_ce;

    // sub-word accesses are accepted as long as they cover byte lane 0
    assign addr_hit = (i_haddr[31:2] == SCR_SYSCTL_OFFS[31:2])
        && (i_haddr[1:0] == 2'h0)
        && (i_hsize <= 3'h2);

    always_comb begin
        ph_next = ph_reg;
        hit_next = hit_reg;
        if (i_ce) begin
            ph_next = SCR_PH_IDLE;
            hit_next = 1'h0;
            if (take) begin
                ph_next = i_hwrite ? SCR_PH_WRITE : SCR_PH_READ;
                hit_next = addr_hit;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ph_reg <= SCR_PH_IDLE;
            hit_reg <= 1'h0;
        end else begin
            ph_reg <= ph_next;
            hit_reg <= hit_next;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// register write in the data phase

    always_comb begin
        wr_now = 1'h0;
        unique case (ph_reg)
            SCR_PH_IDLE: begin
                wr_now = 1'h0;
            end
            SCR_PH_WRITE: begin
                wr_now = hit_reg && i_ce;
            end
            SCR_PH_READ: begin
                wr_now = 1'h0;
            end
            default: begin
                wr_now = 1'h0;
            end
        endcase
    end

    // reserved bits of hwdata are dropped here, so no write reaches them
    scr_bit_reg #(
        .RST(SCR_SRST_RST)
    ) u_srst (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_we(wr_now),
        .i_d(i_hwdata[SCR_BIT_SRST]),
        .o_q(srst_q)
    );

    scr_bit_reg #(
        .RST(SCR_ONCHIP_RAM_ENABLE_RST)
    ) u_onchip_ram_enable (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_we(wr_now),
        .i_d(i_hwdata[SCR_BIT_ONCHIP_RAM_ENABLE]),
        .o_q(onchip_ram_enable_q)
    );

    // value after this edge, so a read right behind a write sees it
    assign srst_next = wr_now ? i_hwdata[SCR_BIT_SRST] : srst_q;
    assign onchip_ram_enable_next = wr_now ? i_hwdata[SCR_BIT_ONCHIP_RAM_ENABLE] : onchip_ram_enable_q;

    assign sys_view = {SCR_RSVD_HI, SCR_RSVD_LO, srst_next, onchip_ram_enable_next};

////////////////////////////////////////////////////////////////////////////////
// read data, loaded at the address phase

    always_comb begin
        hrdata_next = hrdata_reg;
        if (take && !i_hwrite) begin
            hrdata_next = 32'h0000_0000;
            if (addr_hit) begin
                hrdata_next = {24'h00_0000, sys_view};
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            hrdata_reg <= 32'h0000_0000;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    assign o_hrdata = hrdata_reg;

////////////////////////////////////////////////////////////////////////////////
// block outputs

    // zero keeps the trace debug module in its power-on reset
    assign o_trace_debug_rst_n = srst_q;
    assign o_onchip_ram_enable = onchip_ram_enable_q;

////////////////////////////////////////////////////////////////////////////////
// on-chip ram access gate

    scr_ram_if cpu_if ();
    scr_ram_if mem_if ();

    assign cpu_if.req = i_cpu_ram_req;
    assign cpu_if.we = i_cpu_ram_we;
    assign cpu_if.addr = i_cpu_ram_addr;
    assign cpu_if.wdata = i_cpu_ram_wdata;
    assign o_cpu_ram_rdata = cpu_if.rdata;
    assign o_cpu_ram_rvalid = cpu_if.rvalid;

    assign mem_if.rdata = i_mem_rdata;
    assign mem_if.rvalid = 1'h0;
    assign o_mem_req = mem_if.req;
    assign o_mem_we = mem_if.we;
    assign o_mem_addr = mem_if.addr;
    assign o_mem_wdata = mem_if.wdata;

    // the gate reads the enable flop directly: the change lands on the
    // first ram access after the write, well inside the allowed lag
    scr_ram_gate u_gate (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_en(onchip_ram_enable_q),
        .up(cpu_if.gate_up),
        .dn(mem_if.gate_dn)
    );

////////////////////////////////////////////////////////////////////////////////
// checks

    a_rsvd_high: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (take && !i_hwrite && addr_hit)
        |=> (o_hrdata[7:6] == SCR_RSVD_HI))
        else $error("reserved high bits did not read as one");

    a_rsvd_low: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (take && !i_hwrite && addr_hit)
        |=> (o_hrdata[5:2] == SCR_RSVD_LO && o_hrdata[31:8] == 24'h00_0000))
        else $error("reserved low bits did not read as zero");

    a_srst_write: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        wr_now |=> (o_trace_debug_rst_n == $past(i_hwdata[SCR_BIT_SRST])))
        else $error("debug reset bit did not take the written value");

    a_onchip_ram_enable_write: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        wr_now |=> (o_onchip_ram_enable == $past(i_hwdata[SCR_BIT_ONCHIP_RAM_ENABLE])))
        else $error("ram enable did not take the written value");

    a_reset_vals: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> (!o_trace_debug_rst_n && o_onchip_ram_enable))
        else $error("control bits wrong after reset");

    a_readback: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (wr_now ##1 (take && !i_hwrite && addr_hit))
        |=> (o_hrdata[1:0] == $past(i_hwdata[1:0], 2)))
        else $error("register did not read back the written bits");

    a_gate_lag: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (wr_now ##1 i_cpu_ram_req)
        |-> (o_mem_req == $past(i_hwdata[SCR_BIT_ONCHIP_RAM_ENABLE])))
        else $error("ram gate lagged the enable write");

    a_unmapped_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (take && !i_hwrite && !addr_hit) |=> (o_hrdata == 32'h0000_0000))
        else $error("unmapped read did not return zero");

endmodule // scr_sysctl

// [tb/system_control_register_bench.sv]
`timescale 1ns/10ps
module system_control_register_bench
    import scr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = SCR_HTRANS_IDLE;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic dbg_rst_n;
    logic ram_en;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [SCR_RAM_AW-1:0] addr = 12'h05A;
    logic [SCR_DW-1:0] wdata = 32'h0;
    logic [SCR_DW-1:0] rdata;
    logic rvalid;
    logic mem_req;
    logic mem_we;
    logic [SCR_RAM_AW-1:0] mem_addr;
    logic [SCR_DW-1:0] mem_wdata;
    logic [SCR_DW-1:0] mem_rdata = 32'h0;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rd;

    always #50 clk = ~clk;

    scr_sysctl i_scr_sysctl (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .o_trace_debug_rst_n(dbg_rst_n), .o_onchip_ram_enable(ram_en),
        .i_cpu_ram_req(req), .i_cpu_ram_we(we), .i_cpu_ram_addr(addr),
        .i_cpu_ram_wdata(wdata), .o_cpu_ram_rdata(rdata),
        .o_cpu_ram_rvalid(rvalid), .o_mem_req(mem_req), .o_mem_we(mem_we),
        .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .i_mem_rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("mismatches=%0d compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // single word transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= SCR_HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        chk(32'(hresp), 32'(SCR_HRESP_OKAY));
    endtask

    // one ram access; en is whether the gate should pass it
    task automatic ram(input logic w, input logic en, input logic [31:0] exp);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        wdata <= 32'h0BAD_F00D;
        #1;
        chk(32'(mem_req), 32'(en));
        chk(32'(mem_we), 32'(en & w));
        chk(32'(mem_addr), 32'(addr));
        chk(mem_wdata, 32'h0BAD_F00D);
        @(posedge clk);
        req <= 1'b0;
        we <= 1'b0;
        mem_rdata <= exp;
        if (!w) begin
            do begin
                @(posedge clk);
                #1;
            end while (rvalid !== 1'b1);
            chk(rdata, en ? exp : SCR_RAM_UNDEF);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        ahb(1'b0, SCR_SYSCTL_OFFS, 32'h0, rd);
        chk(rd, 32'h0000_00C1);
        chk(32'(dbg_rst_n), 32'h0);
        chk(32'(ram_en), 32'h1);
    endtask

    // reserved bits written against their fixed values must not move
    task automatic t_reserved();
        ahb(1'b1, SCR_SYSCTL_OFFS, 32'h0000_003E, rd);
        ahb(1'b0, SCR_SYSCTL_OFFS, 32'h0, rd);
        chk(rd, 32'h0000_00C2);
        chk(32'(dbg_rst_n), 32'h1);
        chk(32'(ram_en), 32'h0);
        ahb(1'b1, SCR_SYSCTL_OFFS, 32'hFFFF_FFFF, rd);
        ahb(1'b0, SCR_SYSCTL_OFFS, 32'h0, rd);
        chk(rd, 32'h0000_00C3);
        ahb(1'b1, SCR_SYSCTL_OFFS, 32'h0000_00C0, rd);
        ahb(1'b0, SCR_SYSCTL_OFFS, 32'h0, rd);
        chk(rd, 32'h0000_00C0);
        chk(32'(dbg_rst_n), 32'h0);
    endtask

    task automatic t_ram();
        ahb(1'b1, SCR_SYSCTL_OFFS, 32'h0000_00C3, rd);
        ram(1'b1, 1'b1, 32'h0);
        ram(1'b0, 1'b1, 32'hA5A5_0F0F);
        ahb(1'b1, SCR_SYSCTL_OFFS, 32'h0000_00C2, rd);
        ahb(1'b0, SCR_SYSCTL_OFFS, 32'h0, rd);
        ram(1'b0, 1'b0, 32'h1234_5678);
        ram(1'b1, 1'b0, 32'h0);
        ram(1'b0, 1'b0, 32'h5A5A_F0F0);
        ahb(1'b1, SCR_SYSCTL_OFFS, 32'h0000_00C3, rd);
        ahb(1'b0, SCR_SYSCTL_OFFS, 32'h0, rd);
        chk(rd, 32'h0000_00C3);
        ram(1'b0, 1'b1, 32'h3C3C_C3C3);
    endtask

    // an unmapped word reads zero and a write there leaves the register
    task automatic t_unmapped();
        ahb(1'b1, 32'h0000_0004, 32'h0000_00C0, rd);
        ahb(1'b0, 32'h0000_0004, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'b0, SCR_SYSCTL_OFFS, 32'h0, rd);
        chk(rd, 32'h0000_00C3);
    endtask

    // a low clock enable stalls the bus, so a write waits and lands later
    task automatic t_stall();
        @(posedge clk);
        ce <= 1'b0;
        fork
            ahb(1'b1, SCR_SYSCTL_OFFS, 32'h0000_00C2, rd);
            begin
                repeat (3) @(posedge clk);
                chk(32'(hready), 32'h0);
                chk(32'(ram_en), 32'h1);
                ce <= 1'b1;
            end
        join
        ahb(1'b0, SCR_SYSCTL_OFFS, 32'h0, rd);
        chk(rd, 32'h0000_00C2);
        chk(32'(ram_en), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // generous ceiling: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_reserved();
        t_ram();
        t_unmapped();
        t_stall();
        repeat (2) @(posedge clk);
        finish_test();
    end

endmodule // system_control_register_bench
